// *** include/hsc_pkg.sv ***
// hsc_pkg: constants, types and register map of the switch output control
// assumes a 40 MHz system clock; all times are derived from CLK_HZ
package hsc_pkg;

  // ---------------------------------------------------------------------
  // clock and time grain
  // ---------------------------------------------------------------------
  localparam int CLK_HZ   = 40000000;
  localparam int TICK_US  = 100;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;

  // timer on-times in microseconds
  localparam int ON_A_US = 100;
  localparam int ON_B_US = 300;
  localparam int ON_C_US = 1000;
  localparam int ON_D_US = 10000;
  localparam int ON_E_US = 20000;
  // timer periods in milliseconds
  localparam int PER_A_MS = 10;
  localparam int PER_B_MS = 20;
  localparam int PER_C_MS = 50;
  localparam int PER_D_MS = 100;
  localparam int PER_E_MS = 200;
  localparam int PER_F_MS = 1000;
  localparam int PER_G_MS = 2000;

  // pulse channel rates
  localparam int PWM_LO_HZ  = 200;
  localparam int PWM_HI_HZ  = 400;
  localparam int PWM_STEPS  = 255;
  localparam int PWM_LO_CYC = CLK_HZ / (PWM_LO_HZ * PWM_STEPS);
  localparam int PWM_HI_CYC = CLK_HZ / (PWM_HI_HZ * PWM_STEPS);

  // ---------------------------------------------------------------------
  // register map and field positions
  // ---------------------------------------------------------------------
  localparam logic [6:0] ADDR_TIMER_B = 7'h0D;
  localparam logic [6:0] ADDR_SHUTDN  = 7'h10;
  localparam logic [6:0] ADDR_SRC_LO  = 7'h14;
  localparam logic [6:0] ADDR_SRC_HI  = 7'h15;
  localparam logic [6:0] ADDR_HV_PIN  = 7'h17;
  localparam int TMR_ON_LSB  = 4;
  localparam int TMR_PER_LSB = 0;
  localparam int SD_OV_BIT   = 6;
  localparam int SD_UV_BIT   = 5;
  localparam int SD_REC_BIT  = 4;
  localparam int SRC_A_LSB   = 0;
  localparam int SRC_B_LSB   = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [2:0] ON_STOP_LOW  = 3'h0;
  localparam logic [2:0] ON_LAST_RUN  = 3'h5;
  localparam logic [2:0] ON_STOP_HIGH = 3'h6;
  localparam logic [2:0] PER_RSVD     = 3'h7;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_OFF = 3'b000, SRC_ON = 3'b001, SRC_TMR_A = 3'b010,
    SRC_TMR_B = 3'b011, SRC_PWM_A = 3'b100, SRC_PWM_B = 3'b101
  } hsc_src_t;

  typedef enum logic [2:0] {
    HV_OFF = 3'b100, HV_WAKE = 3'b101, HV_LOW = 3'b110, HV_HIGH = 3'b111
  } hsc_hv_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00, SPI_CMD = 2'b01, SPI_DATA = 2'b10, SPI_DONE = 2'b11
  } hsc_spi_t;

  typedef struct packed {
    logic [2:0] timerBOnTime;
    logic [2:0] timerBPeriod;
  } hsc_timer_t;

  typedef struct packed {
    logic overvoltShutdownDisable;
    logic undervoltShutdownDisable;
    logic supplyFaultRecovery;
  } hsc_shutdown_t;

  typedef struct packed {
    logic [1:0] failOutputDuty;
    logic [2:0] hvPinTwoSelect;
    logic [2:0] hvPinOneSelect;
  } hsc_hvpin_t;

  typedef struct packed {
    hsc_timer_t      tmr;
    hsc_shutdown_t   sd;
    logic [3:0][2:0] src;
    hsc_hvpin_t      hv;
  } hsc_regs_t;

endpackage : hsc_pkg

// *** rtl/hsc_output_ctrl.sv ***
// hsc_output_ctrl: register bank, timer b, pulse channels and switch drive
// assumes a mode-0 serial port far slower than sys_clk (sclk <= clk/8)
//
// Operation
// - on-time 000 stops low, 110 stops high, 001-101 give 0.1-20 ms
// - period codes give 10 ms to 2 s; 111 is reserved, timer stays off
// - timer starts on its own once a running on-time is written
// - restart clear with cyclic sensing also clears timer b fields
// - reserved bits always read back as zero
// - over-voltage shuts all switches off unless bit 6 disables it
// - under-voltage shuts all switches off unless bit 5 disables it
// - bit 4 set resumes old switch state; clear leaves switches off
// - 3-bit source per switch: off, on, timer a, timer b
// - sources 100/101 take pulse channel a/b; 110/111 drive nothing
// - overcurrent or overtemperature clears that switch's source field
// - fail output duty field in bits 7:6 selects 20/10/5/2.5 percent
// - pin code 100 disables the pin, 101 makes it a wake input
// - pin code 110 turns on its low-side switch
// - pin code 111 turns on its high-side switch
// - power-on and soft reset load zero into every register
// - pulse duty: 0 off, FF on, else value over 255
// - pulse rate select: 0 is 200 Hz, 1 is 400 Hz
`timescale 1ns/1ps
`default_nettype none

module hsc_output_ctrl (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            softRst,
  input  wire logic            restartClr,
  input  wire logic            cyclicSense,
  input  wire logic            spiSclk,
  input  wire logic            spiCsN,
  input  wire logic            spiMosi,
  output var  logic            spiMiso,
  output var  logic            spiMisoOe,
  input  wire logic            supplyOverVolt,
  input  wire logic            supplyUnderVolt,
  input  wire logic [3:0]      switchFault,
  input  wire logic            timerALevel,
  input  wire logic [1:0][7:0] pulseDuty,
  input  wire logic [1:0]      pulseFreqSel,
  output var  logic [3:0]      switchOutput,
  output var  logic [1:0]      failOutEn,
  output var  logic [1:0]      wakeInEn,
  output var  logic [1:0]      lowSideOn,
  output var  logic [1:0]      highSideOn,
  output var  logic [1:0]      failOutputDuty
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  // order: sclk, csN, mosi, ov, uv, fault[3:0]
  // reset at idle levels (sclk low, csN high) so no false edge follows
  logic [8:0] syn1_q, syn2_q;
  logic       edge_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syn1_q <= 9'h002;
      syn2_q <= 9'h002;
      edge_q <= 1'b0;
    end else begin
      syn1_q <= {switchFault, supplyUnderVolt, supplyOverVolt, spiMosi,
                 spiCsN, spiSclk};
      syn2_q <= syn1_q;
      edge_q <= syn2_q[0];
    end
  end
  logic sclkRise, sclkFall, csIdle, mosiS, ovS, uvS;
  logic [3:0] faultS;
  assign sclkRise = syn2_q[0] & ~edge_q;
  assign sclkFall = ~syn2_q[0] & edge_q;
  assign csIdle   = syn2_q[1];
  assign mosiS    = syn2_q[2];
  assign ovS      = syn2_q[3];
  assign uvS      = syn2_q[4];
  assign faultS   = syn2_q[8:5];

  hsc_pkg::hsc_regs_t regs_q, regs_d;

  // reserved positions are never stored, so they can only read as zero
  function automatic logic [7:0] rdMux(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      hsc_pkg::ADDR_TIMER_B: begin
        r[hsc_pkg::TMR_ON_LSB +: 3]  = regs_q.tmr.timerBOnTime;
        r[hsc_pkg::TMR_PER_LSB +: 3] = regs_q.tmr.timerBPeriod;
      end
      hsc_pkg::ADDR_SHUTDN: begin
        r[hsc_pkg::SD_OV_BIT]  = regs_q.sd.overvoltShutdownDisable;
        r[hsc_pkg::SD_UV_BIT]  = regs_q.sd.undervoltShutdownDisable;
        r[hsc_pkg::SD_REC_BIT] = regs_q.sd.supplyFaultRecovery;
      end
      hsc_pkg::ADDR_SRC_LO: begin
        r[hsc_pkg::SRC_A_LSB +: 3] = regs_q.src[0];
        r[hsc_pkg::SRC_B_LSB +: 3] = regs_q.src[1];
      end
      hsc_pkg::ADDR_SRC_HI: begin
        r[hsc_pkg::SRC_A_LSB +: 3] = regs_q.src[2];
        r[hsc_pkg::SRC_B_LSB +: 3] = regs_q.src[3];
      end
      hsc_pkg::ADDR_HV_PIN: r = regs_q.hv;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rdMux

  // ---------------------------------------------------------------------
  // serial slave: 7 address bits, write flag, 8 data bits, msb first
  // ---------------------------------------------------------------------
  hsc_pkg::hsc_spi_t spi_q, spi_d;
  logic [4:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, out_q, out_d, wdat_q, wdat_d;
  logic [6:0] addr_q, addr_d;
  logic       wr_q, wr_d, stb_q, stb_d, miso_q, miso_d, oe_q, oe_d;
  logic [7:0] rdNow;
  always_comb begin
    spi_d = spi_q; bit_d = bit_q; sh_d = sh_q; out_d = out_q;
    addr_d = addr_q; wr_d = wr_q; miso_d = miso_q; oe_d = oe_q;
    wdat_d = wdat_q; stb_d = 1'b0;
    rdNow = rdMux(sh_q[6:0]);
    if (csIdle) begin
      spi_d = hsc_pkg::SPI_IDLE; oe_d = 1'b0; bit_d = 5'h00;
    end else begin
      case (spi_q)
        hsc_pkg::SPI_IDLE: begin
          spi_d = hsc_pkg::SPI_CMD; oe_d = 1'b1; miso_d = 1'b0;
        end
        hsc_pkg::SPI_CMD: if (sclkRise) begin
          sh_d  = {sh_q[6:0], mosiS};
          bit_d = bit_q + 5'h01;
          if (bit_q == 5'h07) begin
            addr_d = sh_q[6:0]; wr_d = mosiS;
            miso_d = rdNow[7];
            out_d  = {rdNow[6:0], 1'b0};
            spi_d  = hsc_pkg::SPI_DATA;
          end
        end
        hsc_pkg::SPI_DATA: begin
          if (sclkRise) begin
            sh_d  = {sh_q[6:0], mosiS};
            bit_d = bit_q + 5'h01;
            if (bit_q == 5'h0F) begin
              wdat_d = {sh_q[6:0], mosiS};
              stb_d  = wr_q;
              spi_d  = hsc_pkg::SPI_DONE;
            end
          end else if (sclkFall && bit_q > 5'h08) begin
            miso_d = out_q[7];
            out_d  = {out_q[6:0], 1'b0};
          end
        end
        hsc_pkg::SPI_DONE: spi_d = hsc_pkg::SPI_DONE;
        default: spi_d = hsc_pkg::SPI_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_q <= hsc_pkg::SPI_IDLE; bit_q <= 5'h00; sh_q <= 8'h00;
      out_q <= 8'h00; addr_q <= 7'h00; wr_q <= 1'b0; stb_q <= 1'b0;
      miso_q <= 1'b0; oe_q <= 1'b0; wdat_q <= 8'h00;
    end else begin
      spi_q <= spi_d; bit_q <= bit_d; sh_q <= sh_d; out_q <= out_d;
      addr_q <= addr_d; wr_q <= wr_d; stb_q <= stb_d;
      miso_q <= miso_d; oe_q <= oe_d; wdat_q <= wdat_d;
    end
  end
  assign spiMiso   = miso_q;
  assign spiMisoOe = oe_q;

  // ---------------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------------
  logic sdActive, sdPrev_q, sdEntry;
  assign sdActive = (ovS & ~regs_q.sd.overvoltShutdownDisable) |
                    (uvS & ~regs_q.sd.undervoltShutdownDisable);
  assign sdEntry  = sdActive & ~sdPrev_q;
  always_comb begin
    regs_d = regs_q;
    if (stb_q) begin
      case (addr_q)
        hsc_pkg::ADDR_TIMER_B: begin
          regs_d.tmr.timerBOnTime = wdat_q[hsc_pkg::TMR_ON_LSB +: 3];
          regs_d.tmr.timerBPeriod = wdat_q[hsc_pkg::TMR_PER_LSB +: 3];
        end
        hsc_pkg::ADDR_SHUTDN: begin
          regs_d.sd.overvoltShutdownDisable  = wdat_q[hsc_pkg::SD_OV_BIT];
          regs_d.sd.undervoltShutdownDisable = wdat_q[hsc_pkg::SD_UV_BIT];
          regs_d.sd.supplyFaultRecovery      = wdat_q[hsc_pkg::SD_REC_BIT];
        end
        hsc_pkg::ADDR_SRC_LO: begin
          regs_d.src[0] = wdat_q[hsc_pkg::SRC_A_LSB +: 3];
          regs_d.src[1] = wdat_q[hsc_pkg::SRC_B_LSB +: 3];
        end
        hsc_pkg::ADDR_SRC_HI: begin
          regs_d.src[2] = wdat_q[hsc_pkg::SRC_A_LSB +: 3];
          regs_d.src[3] = wdat_q[hsc_pkg::SRC_B_LSB +: 3];
        end
        hsc_pkg::ADDR_HV_PIN: regs_d.hv = wdat_q;
        default: regs_d = regs_d;
      endcase
    end
    // hardware clears win over a write landing in the same cycle
    if (restartClr) begin
      regs_d.src = '0;
      if (cyclicSense) regs_d.tmr = '0;
    end
    if (sdEntry && !regs_q.sd.supplyFaultRecovery) regs_d.src = '0;
    for (int i = 0; i < 4; i++) begin
      if (faultS[i]) regs_d.src[i] = 3'h0;
    end
    if (softRst) regs_d = hsc_pkg::hsc_regs_t'(0);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) regs_q <= hsc_pkg::hsc_regs_t'(0);
    else     regs_q <= regs_d;
  end

  // ---------------------------------------------------------------------
  // timer b
  // ---------------------------------------------------------------------
  function automatic logic [14:0] onTicks(input logic [2:0] c);
    case (c)
      3'h1:    return 15'(hsc_pkg::ON_A_US / hsc_pkg::TICK_US);
      3'h2:    return 15'(hsc_pkg::ON_B_US / hsc_pkg::TICK_US);
      3'h3:    return 15'(hsc_pkg::ON_C_US / hsc_pkg::TICK_US);
      3'h4:    return 15'(hsc_pkg::ON_D_US / hsc_pkg::TICK_US);
      3'h5:    return 15'(hsc_pkg::ON_E_US / hsc_pkg::TICK_US);
      default: return 15'h0000;
    endcase
  endfunction : onTicks
  function automatic logic [14:0] perTicks(input logic [2:0] c);
    case (c)
      3'h0: return 15'(hsc_pkg::PER_A_MS * 1000 / hsc_pkg::TICK_US);
      3'h1: return 15'(hsc_pkg::PER_B_MS * 1000 / hsc_pkg::TICK_US);
      3'h2: return 15'(hsc_pkg::PER_C_MS * 1000 / hsc_pkg::TICK_US);
      3'h3: return 15'(hsc_pkg::PER_D_MS * 1000 / hsc_pkg::TICK_US);
      3'h4: return 15'(hsc_pkg::PER_E_MS * 1000 / hsc_pkg::TICK_US);
      3'h5: return 15'(hsc_pkg::PER_F_MS * 1000 / hsc_pkg::TICK_US);
      3'h6: return 15'(hsc_pkg::PER_G_MS * 1000 / hsc_pkg::TICK_US);
      default: return 15'h0001;
    endcase
  endfunction : perTicks

  logic [11:0] pre_q, pre_d;
  logic [14:0] cnt_q, cnt_d;
  hsc_pkg::hsc_timer_t tPrev_q;
  logic tbLvl_q, tbLvl_d, tbRun, tick;
  // a reserved period leaves the timer idle rather than guess a length
  assign tbRun = regs_q.tmr.timerBOnTime != hsc_pkg::ON_STOP_LOW &&
                 regs_q.tmr.timerBOnTime <= hsc_pkg::ON_LAST_RUN &&
                 regs_q.tmr.timerBPeriod != hsc_pkg::PER_RSVD;
  assign tick  = pre_q == 12'(hsc_pkg::TICK_CYC - 1);
  always_comb begin
    pre_d = tick ? 12'h000 : pre_q + 12'h001;
    cnt_d = cnt_q;
    // any new setting restarts the cycle from its on-phase
    if (!tbRun || regs_q.tmr != tPrev_q) begin
      cnt_d = 15'h0000;
      pre_d = 12'h000;
    end else if (tick) begin
      cnt_d = (cnt_q == perTicks(regs_q.tmr.timerBPeriod) - 15'h0001) ?
              15'h0000 : cnt_q + 15'h0001;
    end
    tbLvl_d = regs_q.tmr.timerBOnTime == hsc_pkg::ON_STOP_HIGH ||
              (tbRun && cnt_q < onTicks(regs_q.tmr.timerBOnTime));
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_q <= 12'h000; cnt_q <= 15'h0000; tbLvl_q <= 1'b0;
      tPrev_q <= '0;
    end else begin
      pre_q <= pre_d; cnt_q <= cnt_d; tbLvl_q <= tbLvl_d;
      tPrev_q <= regs_q.tmr;
    end
  end

  // ---------------------------------------------------------------------
  // pulse channels a and b
  // ---------------------------------------------------------------------
  logic [1:0] pwmLvl;
  for (genvar g = 0; g < 2; g++) begin : gPwm
    logic [9:0] step_q, step_d, lim;
    logic [7:0] ph_q, ph_d;
    logic       lvl_q, lvl_d;
    assign lim = pulseFreqSel[g] ? 10'(hsc_pkg::PWM_HI_CYC - 1) :
                                   10'(hsc_pkg::PWM_LO_CYC - 1);
    always_comb begin
      step_d = step_q + 10'h001;
      ph_d   = ph_q;
      if (step_q >= lim) begin
        step_d = 10'h000;
        ph_d   = (ph_q == 8'(hsc_pkg::PWM_STEPS - 1)) ? 8'h00 : ph_q + 8'h01;
      end
      lvl_d = pulseDuty[g] == 8'hFF || ph_q < pulseDuty[g];
    end
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        step_q <= 10'h000; ph_q <= 8'h00; lvl_q <= 1'b0;
      end else begin
        step_q <= step_d; ph_q <= ph_d; lvl_q <= lvl_d;
      end
    end
    assign pwmLvl[g] = lvl_q;
  end

  // ---------------------------------------------------------------------
  // switch and pin drive
  // ---------------------------------------------------------------------
  logic [3:0] sw_q, sw_d;
  logic [1:0] fo_q, fo_d, wk_q, wk_d, ls_q, ls_d, hs_q, hs_d;
  logic [2:0] pSel;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (regs_q.src[i])
        hsc_pkg::SRC_OFF:   sw_d[i] = 1'b0;
        hsc_pkg::SRC_ON:    sw_d[i] = 1'b1;
        hsc_pkg::SRC_TMR_A: sw_d[i] = timerALevel;
        hsc_pkg::SRC_TMR_B: sw_d[i] = tbLvl_q;
        hsc_pkg::SRC_PWM_A: sw_d[i] = pwmLvl[0];
        hsc_pkg::SRC_PWM_B: sw_d[i] = pwmLvl[1];
        default:            sw_d[i] = 1'b0;
      endcase
    end
    if (sdActive) sw_d = 4'h0;
    for (int p = 0; p < 2; p++) begin
      pSel = p == 0 ? regs_q.hv.hvPinOneSelect : regs_q.hv.hvPinTwoSelect;
      fo_d[p] = ~pSel[2];
      wk_d[p] = pSel == hsc_pkg::HV_WAKE;
      ls_d[p] = pSel == hsc_pkg::HV_LOW;
      hs_d[p] = pSel == hsc_pkg::HV_HIGH;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_q <= 4'h0; fo_q <= 2'h0; wk_q <= 2'h0; ls_q <= 2'h0;
      hs_q <= 2'h0; sdPrev_q <= 1'b0;
    end else begin
      sw_q <= sw_d; fo_q <= fo_d; wk_q <= wk_d; ls_q <= ls_d;
      hs_q <= hs_d; sdPrev_q <= sdActive;
    end
  end
  assign switchOutput   = sw_q;
  assign failOutEn      = fo_q;
  assign wakeInEn       = wk_q;
  assign lowSideOn      = ls_q;
  assign highSideOn     = hs_q;
  assign failOutputDuty = regs_q.hv.failOutputDuty;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_stopLow;
    regs_q.tmr.timerBOnTime == 3'h0 ##1
    regs_q.tmr.timerBOnTime == 3'h0 |-> !tbLvl_q;
  endproperty
  a_stopLow: assert property (p_stopLow) else $error("stop-low not low");
  property p_stopHigh;
    $past(regs_q.tmr.timerBOnTime) == 3'h6 |-> tbLvl_q;
  endproperty
  a_stopHigh: assert property (p_stopHigh) else $error("stop-high low");
  property p_restartTmr;
    restartClr && cyclicSense && !softRst |=> regs_q.tmr == '0 &&
    regs_q.src == '0;
  endproperty
  a_restartTmr: assert property (p_restartTmr) else $error("tmr kept");
  property p_rsvdZero;
    spi_q == hsc_pkg::SPI_CMD && bit_q == 5'h07 && sclkRise &&
    sh_q[6:0] == hsc_pkg::ADDR_SHUTDN |=> !miso_q;
  endproperty
  a_rsvdZero: assert property (p_rsvdZero) else $error("rsvd set");
  property p_ovOff;
    ovS && !regs_q.sd.overvoltShutdownDisable |=> sw_q == 4'h0;
  endproperty
  a_ovOff: assert property (p_ovOff) else $error("ov left on");
  property p_uvOff;
    uvS && !regs_q.sd.undervoltShutdownDisable |=> sw_q == 4'h0;
  endproperty
  a_uvOff: assert property (p_uvOff) else $error("uv left on");
  property p_noRecover;
    sdEntry && !regs_q.sd.supplyFaultRecovery |=> regs_q.src == '0;
  endproperty
  a_noRecover: assert property (p_noRecover) else $error("src kept");
  property p_faultClr;
    faultS[0] |=> regs_q.src[0] == 3'h0 [*2];
  endproperty
  a_faultClr: assert property (p_faultClr) else $error("fault kept");
  property p_softRst;
    softRst |=> regs_q == '0;
  endproperty
  a_softRst: assert property (p_softRst) else $error("not cleared");
  property p_srcOn;
    regs_q.src[1] == 3'h1 && !sdActive |=> sw_q[1];
  endproperty
  a_srcOn: assert property (p_srcOn) else $error("on not driven");

  c_write: cover property (stb_q && addr_q == hsc_pkg::ADDR_SRC_LO);
  c_tbRise: cover property (tbRun && $rose(tbLvl_q));
  c_recover: cover property ($fell(sdActive) ##1 sw_q != 4'h0);
  c_fault: cover property (faultS != 4'h0 && regs_q.src != '0);

endmodule : hsc_output_ctrl

`default_nettype wire

// *** testbench/hsc_output_ctrl_test.sv ***
// hsc_output_ctrl_test: register, switch and pin tests over the serial port
// assumes the bench alone drives every input; sclk high phases last 7 sys_clk, low phases 8
`timescale 1ns/1ps
`default_nettype none

module hsc_output_ctrl_test;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  localparam logic [6:0] A_TB = hsc_pkg::ADDR_TIMER_B;
  localparam logic [6:0] A_SD = hsc_pkg::ADDR_SHUTDN;
  localparam logic [6:0] A_LO = hsc_pkg::ADDR_SRC_LO;
  localparam logic [6:0] A_HI = hsc_pkg::ADDR_SRC_HI;
  localparam logic [6:0] A_HV = hsc_pkg::ADDR_HV_PIN;
  localparam logic [7:0] SRC_EXP = 8'h16;
  logic            sys_clk, rst, softRst, restartClr, cyclicSense;
  logic            spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe;
  logic            supplyOverVolt, supplyUnderVolt, timerALevel;
  logic [3:0]      switchFault, switchOutput;
  logic [1:0][7:0] pulseDuty;
  logic [1:0]      pulseFreqSel, failOutEn, wakeInEn, lowSideOn;
  logic [1:0]      highSideOn, failOutputDuty;
  logic [6:0]      adr [5] = '{A_TB, A_SD, A_LO, A_HI, A_HV};
  logic [7:0]      msk [5] = '{8'h77, 8'h70, 8'h77, 8'h77, 8'hFF};
  int              errorCnt, comparisons;

  hsc_output_ctrl u_hsc_output_ctrl (.sys_clk(sys_clk), .rst(rst),
    .softRst(softRst), .restartClr(restartClr), .cyclicSense(cyclicSense),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .supplyOverVolt(supplyOverVolt), .supplyUnderVolt(supplyUnderVolt),
    .switchFault(switchFault), .timerALevel(timerALevel),
    .pulseDuty(pulseDuty), .pulseFreqSel(pulseFreqSel),
    .switchOutput(switchOutput), .failOutEn(failOutEn),
    .wakeInEn(wakeInEn), .lowSideOn(lowSideOn), .highSideOn(highSideOn),
    .failOutputDuty(failOutputDuty));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic final_report;
    if (errorCnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one whole 16-bit frame; miso sampled on the low phase before each of the last 8 rises
  task automatic xfer(input logic [6:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, w, d};
    q = 8'h00;
    @(posedge sys_clk) spiCsN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge sys_clk) spiMosi <= f[i];
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) if (i < 8) q[i] = spiMiso;
      @(posedge sys_clk) spiSclk <= 1'b1;
      repeat (6) @(posedge sys_clk);
      @(posedge sys_clk) spiSclk <= 1'b0;
    end
    @(negedge sys_clk) chk({7'h00, spiMisoOe}, 8'h01);
    repeat (6) @(posedge sys_clk);
    spiCsN <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // outputs are looked at on the falling edge, where they are settled
    @(negedge sys_clk) chk({7'h00, spiMisoOe}, 8'h00);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask : rc

  task automatic so(input logic e);
    @(negedge sys_clk);
    chk({7'h00, switchOutput[0]}, {7'h00, e});
  endtask : so

  task automatic pulse(input logic o, input logic u, input logic f);
    @(posedge sys_clk);
    supplyOverVolt <= o;
    supplyUnderVolt <= u;
    switchFault <= {3'h0, f};
    repeat (6) @(posedge sys_clk);
  endtask : pulse

  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  initial begin
    rst <= 1'b1; softRst <= 1'b0; restartClr <= 1'b0; cyclicSense <= 1'b0;
    spiSclk <= 1'b0; spiCsN <= 1'b1; spiMosi <= 1'b0; timerALevel <= 1'b1;
    supplyOverVolt <= 1'b0; supplyUnderVolt <= 1'b0; switchFault <= 4'h0;
    pulseDuty <= {8'h00, 8'hFF}; pulseFreqSel <= 2'h1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rc(adr[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 8'hFF);
      rc(adr[i], msk[i]);
    end
    rc(7'h01, 8'h00);
    @(posedge sys_clk) softRst <= 1'b1;
    @(posedge sys_clk) softRst <= 1'b0;
    for (int i = 0; i < 5; i++) rc(adr[i], 8'h00);
    // pulse a is full on, b full off, timer a high, timer b idle
    for (int c = 0; c < 8; c++) begin
      wr(A_LO, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr(A_HI, {1'b0, 3'(c), 1'b0, 3'(c)});
      chk({4'h0, switchOutput}, {8{SRC_EXP[c]}} & 8'h0F);
    end
    wr(A_LO, 8'h03);
    wr(A_TB, 8'h60);
    so(1'b1);
    wr(A_TB, 8'h17);
    so(1'b0);
    wr(A_TB, 8'h10);
    so(1'b1);
    repeat (4100) @(posedge sys_clk);
    so(1'b0);
    @(posedge sys_clk) {cyclicSense, restartClr} <= 2'h3;
    @(posedge sys_clk) restartClr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rc(A_TB, 8'h00);
    rc(A_LO, 8'h00);
    wr(A_LO, 8'h01);
    pulse(1'b1, 1'b0, 1'b0);
    so(1'b0);
    pulse(1'b0, 1'b0, 1'b0);
    so(1'b0);
    rc(A_LO, 8'h00);
    wr(A_SD, 8'h40);
    wr(A_LO, 8'h01);
    pulse(1'b1, 1'b0, 1'b0);
    so(1'b1);
    wr(A_SD, 8'h10);
    pulse(1'b0, 1'b1, 1'b0);
    so(1'b0);
    pulse(1'b0, 1'b0, 1'b0);
    so(1'b1);
    pulse(1'b0, 1'b0, 1'b1);
    pulse(1'b0, 1'b0, 1'b0);
    rc(A_LO, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(A_HV, {2'(c), 3'(c), 3'(c)});
      chk({failOutEn, wakeInEn, lowSideOn, highSideOn},
          {{2{c < 4}}, {2{c == 5}}, {2{c == 6}}, {2{c == 7}}});
      chk({6'h00, failOutputDuty}, {6'h00, 2'(c)});
    end
    final_report();
  end

  // whole run needs roughly 19k cycles; a hang stops it at 90k
  initial begin
    repeat (90000) @(posedge sys_clk);
    errorCnt++;
    final_report();
  end
endmodule : hsc_output_ctrl_test

`default_nettype wire
